/* src/bmba_arbiter.sv */
// Purpose: Buffer memory bus arbiter with reset, idle and master states.
// Assumes: All requesters and error strobes run on aclk.
// Notes:   Registers are reached over an AXI4-Lite slave port.
// Operation
// - Device is only ever a slave on its host-side bus port.
// - Memory bus is master, CPU-accessed slave, or idle; never more.
// - Hard reset leaves reset state with receiver and transmitter disabled.
// - Stop command, register reset or hard reset return to reset state.
// - FIFO underflow, overflow or ring overflow return to reset state.
// - Software sets registers, then start moves reset to idle.
// - A FIFO request takes the arbiter from idle to driving the bus.
// - In I/O mode the remote DMA requests the bus when programmed.
// - In shared-memory mode the CPU reaches the bus directly.
// - Each local burst moves exactly the configured byte count then releases.
// - A new local burst waits until FIFO level exceeds the threshold.
// - In I/O mode all host data moves through the remote DMA port.
// - Local DMA preempts pending or running remote transfers.
// - After local DMA the remote DMA rearbitrates and resumes.
// - FIFO service during remote DMA follows the current remote word.
// - A gap follows local-to-remote handover so the CPU can contend.
// - Remote DMA never takes the RAM during a local burst.
// - Remote DMA arbitrates and releases the RAM once per word.
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "bmba_regs.svh"

module bmba_arbiter #(
    parameter int ADDR_W = 8,
    parameter int LVL_W  = 5
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              fifo_req,
    input  wire logic [LVL_W-1:0]  fifo_level,
    input  wire logic              rdma_req,
    input  wire logic              cpu_req,
    input  wire logic              fifo_underrun,
    input  wire logic              fifo_overrun,
    input  wire logic              ring_overflow,
    output bmba_pkg::bmba_grant_t  grant_q,
    output logic                   mem_cycle_q,
    output logic                   rxtx_en_q,
    output logic                   burst_done_q,
    output logic                   word_done_q,
    output logic                   irq_q
);

    ////////////////////////////////////////////////////////////////////////////////
    bmba_pkg::bmba_state_t state_q;
    bmba_pkg::bmba_state_t state_d;
    bmba_pkg::bmba_cfg_t   cfg_q;
    logic                  shared_q;
    logic [3:0]            byte_cnt_q;
    logic [1:0]            word_cnt_q;
    logic [`BMBA_INT_W-1:0] isr_q;
    logic [`BMBA_INT_W-1:0] imr_q;
    logic [`BMBA_INT_W-1:0] int_set;
    logic [`BMBA_INT_W-1:0] int_clr;
    logic [ADDR_W-1:0]     awaddr_q;
    logic [31:0]           wdata_q;
    logic                  wstrb0_q;
    logic                  aw_have_q;
    logic                  w_have_q;
    logic                  wr_fire;
    logic                  wr_hit;
    logic [31:0]           rd_mux;
    logic                  rd_hit;
    logic                  start_p;
    logic                  stop_p;
    logic                  rreset_p;
    logic                  err_any;
    logic                  abort;
    logic                  lreq;
    logic                  rem_ok;
    logic                  cpu_ok;
    logic [3:0]            burst_last;
    logic                  loc_end;
    logic                  rem_end;

    ////////////////////////////////////////////////////////////////////////////////
    // The port only answers; it never starts a transaction of its own.
    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_hit  = (awaddr_q == `BMBA_OFF_CTRL) || (awaddr_q == `BMBA_OFF_CFG) ||
                     (awaddr_q == `BMBA_OFF_STAT) || (awaddr_q == `BMBA_OFF_ISR) ||
                     (awaddr_q == `BMBA_OFF_IMR);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            aw_have_q     <= 1'b0;
            awaddr_q      <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_have_q     <= 1'b1;
            awaddr_q      <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_have_q     <= 1'b0;
        end else if (!aw_have_q && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
            w_have_q     <= 1'b0;
            wdata_q      <= '0;
            wstrb0_q     <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_have_q     <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb0_q     <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_have_q     <= 1'b0;
        end else if (!w_have_q && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `BMBA_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `BMBA_RESP_OKAY : `BMBA_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Only byte lane 0 carries fields; other lanes are ignored.
    assign start_p  = wr_fire && wstrb0_q && (awaddr_q == `BMBA_OFF_CTRL) &&
                      wdata_q[`BMBA_CTRL_START];
    assign stop_p   = wr_fire && wstrb0_q && (awaddr_q == `BMBA_OFF_CTRL) &&
                      wdata_q[`BMBA_CTRL_STOP];
    assign rreset_p = wr_fire && wstrb0_q && (awaddr_q == `BMBA_OFF_CTRL) &&
                      wdata_q[`BMBA_CTRL_RRESET];
    assign int_clr  = (wr_fire && wstrb0_q && (awaddr_q == `BMBA_OFF_ISR)) ?
                      wdata_q[`BMBA_INT_W-1:0] : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shared_q <= 1'b0;
            cfg_q    <= '{thresh: `BMBA_CFG_THR_RST, burst: `BMBA_CFG_BURST_RST};
            imr_q    <= '0;
        end else if (wr_fire && wstrb0_q) begin
            if (awaddr_q == `BMBA_OFF_CTRL) begin
                shared_q <= wdata_q[`BMBA_CTRL_SHARED];
            end
            if (awaddr_q == `BMBA_OFF_CFG) begin
                cfg_q.burst  <= wdata_q[`BMBA_CFG_BURST_HI:`BMBA_CFG_BURST_LO];
                cfg_q.thresh <= wdata_q[`BMBA_CFG_THR_HI:`BMBA_CFG_THR_LO];
            end
            if (awaddr_q == `BMBA_OFF_IMR) begin
                imr_q <= wdata_q[`BMBA_INT_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        rd_mux = '0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `BMBA_OFF_CTRL: rd_mux[`BMBA_CTRL_SHARED] = shared_q;
            `BMBA_OFF_CFG:  rd_mux[7:0] = {cfg_q.thresh, cfg_q.burst};
            `BMBA_OFF_STAT: rd_mux[6:0] = {rxtx_en_q, state_q};
            `BMBA_OFF_ISR:  rd_mux[`BMBA_INT_W-1:0] = isr_q;
            `BMBA_OFF_IMR:  rd_mux[`BMBA_INT_W-1:0] = imr_q;
            default:        rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `BMBA_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= rd_hit ? `BMBA_RESP_OKAY : `BMBA_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign err_any = fifo_underrun || fifo_overrun || ring_overflow;
    assign abort   = stop_p || rreset_p || err_any;
    // Threshold gating also covers the first burst, so a FIFO that asks early waits.
    assign lreq    = fifo_req && (fifo_level > LVL_W'(cfg_q.thresh));
    assign rem_ok  = rdma_req && !shared_q;
    assign cpu_ok  = cpu_req && shared_q;
    // A burst field of zero wraps to the full sixteen bytes.
    assign burst_last = cfg_q.burst - 4'h1;
    assign loc_end = (byte_cnt_q == burst_last);
    assign rem_end = (word_cnt_q == `BMBA_WORD_LAST);

    always_comb begin
        state_d = state_q;
        case (state_q)
            bmba_pkg::BMBA_RESET: begin
                if (start_p) begin
                    state_d = bmba_pkg::BMBA_IDLE;
                end
            end
            bmba_pkg::BMBA_IDLE: begin
                if (lreq) begin
                    state_d = bmba_pkg::BMBA_LOCAL;
                end else if (rem_ok) begin
                    state_d = bmba_pkg::BMBA_REMOTE;
                end else if (cpu_ok) begin
                    state_d = bmba_pkg::BMBA_CPU;
                end
            end
            bmba_pkg::BMBA_LOCAL: begin
                if (loc_end) begin
                    state_d = (rem_ok || cpu_ok) ? bmba_pkg::BMBA_GAP
                                                 : bmba_pkg::BMBA_IDLE;
                end
            end
            bmba_pkg::BMBA_REMOTE: begin
                if (rem_end) begin
                    state_d = lreq ? bmba_pkg::BMBA_LOCAL : bmba_pkg::BMBA_IDLE;
                end
            end
            bmba_pkg::BMBA_GAP: begin
                // The break hands the first chance to the CPU or remote side.
                if (cpu_ok) begin
                    state_d = bmba_pkg::BMBA_CPU;
                end else if (rem_ok) begin
                    state_d = bmba_pkg::BMBA_REMOTE;
                end else if (lreq) begin
                    state_d = bmba_pkg::BMBA_LOCAL;
                end else begin
                    state_d = bmba_pkg::BMBA_IDLE;
                end
            end
            bmba_pkg::BMBA_CPU: begin
                if (!cpu_ok) begin
                    state_d = bmba_pkg::BMBA_IDLE;
                end
            end
            default: state_d = bmba_pkg::BMBA_RESET;
        endcase
        if (abort) begin
            state_d = bmba_pkg::BMBA_RESET;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= bmba_pkg::BMBA_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || state_q != bmba_pkg::BMBA_LOCAL) begin
            byte_cnt_q <= '0;
        end else begin
            byte_cnt_q <= byte_cnt_q + 4'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || state_q != bmba_pkg::BMBA_REMOTE) begin
            word_cnt_q <= '0;
        end else begin
            word_cnt_q <= word_cnt_q + 2'h1;
        end
    end

    // Outputs are decoded from the next state so they line up with state_q.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            grant_q     <= '0;
            mem_cycle_q <= 1'b0;
            rxtx_en_q   <= 1'b0;
        end else begin
            grant_q.local_dma  <= (state_d == bmba_pkg::BMBA_LOCAL);
            grant_q.remote_dma <= (state_d == bmba_pkg::BMBA_REMOTE);
            grant_q.cpu        <= (state_d == bmba_pkg::BMBA_CPU);
            mem_cycle_q        <= (state_d == bmba_pkg::BMBA_LOCAL) ||
                                  (state_d == bmba_pkg::BMBA_REMOTE);
            rxtx_en_q          <= (state_d != bmba_pkg::BMBA_RESET);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            burst_done_q <= 1'b0;
            word_done_q  <= 1'b0;
        end else begin
            burst_done_q <= (state_q == bmba_pkg::BMBA_LOCAL) && loc_end && !abort;
            word_done_q  <= (state_q == bmba_pkg::BMBA_REMOTE) && rem_end && !abort;
        end
    end

    always_comb begin
        int_set = '0;
        int_set[`BMBA_INT_ERR]   = err_any;
        int_set[`BMBA_INT_BURST] = burst_done_q;
        int_set[`BMBA_INT_WORD]  = word_done_q;
    end

    // A set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            isr_q <= '0;
            irq_q <= 1'b0;
        end else begin
            isr_q <= (isr_q & ~int_clr) | int_set;
            irq_q <= |(((isr_q & ~int_clr) | int_set) & imr_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    logic [4:0] loc_len_q;
    logic [4:0] burst_exp;

    assign burst_exp = (cfg_q.burst == 4'h0) ? `BMBA_BURST_FULL : {1'b0, cfg_q.burst};

    always_ff @(posedge aclk) begin
        if (!aresetn || !grant_q.local_dma) begin
            loc_len_q <= '0;
        end else begin
            loc_len_q <= loc_len_q + 5'h01;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_remote_word;
        grant_q.remote_dma [*2];
    endsequence

    sequence s_release;
        !grant_q.remote_dma;
    endsequence

    property p_one_grant;
        $onehot0(grant_q);
    endproperty
    a_one_grant: assert property (p_one_grant) else $error("more than one grant");

    property p_quiet_states;
        (state_q == bmba_pkg::BMBA_RESET || state_q == bmba_pkg::BMBA_IDLE) |->
            (grant_q == '0 && !mem_cycle_q);
    endproperty
    a_quiet_states: assert property (p_quiet_states) else $error("bus active when quiet");

    property p_err_reset;
        err_any |=> (state_q == bmba_pkg::BMBA_RESET) && !rxtx_en_q ##1 grant_q == '0;
    endproperty
    a_err_reset: assert property (p_err_reset) else $error("error did not reset");

    property p_stop_reset;
        (stop_p || rreset_p) |=> state_q == bmba_pkg::BMBA_RESET;
    endproperty
    a_stop_reset: assert property (p_stop_reset) else $error("stop did not reset");

    property p_start;
        (state_q == bmba_pkg::BMBA_RESET && start_p && !abort) |=>
            (state_q == bmba_pkg::BMBA_IDLE) && rxtx_en_q;
    endproperty
    a_start: assert property (p_start) else $error("start did not enter idle");

    property p_burst_len;
        ($fell(grant_q.local_dma) && !$past(abort)) |-> loc_len_q == burst_exp;
    endproperty
    a_burst_len: assert property (p_burst_len) else $error("wrong burst length");

    property p_local_first;
        (state_q == bmba_pkg::BMBA_IDLE && lreq && !abort) |=> grant_q.local_dma;
    endproperty
    a_local_first: assert property (p_local_first) else $error("local not preferred");

    property p_thresh;
        $rose(grant_q.local_dma) |-> $past(lreq);
    endproperty
    a_thresh: assert property (p_thresh) else $error("burst below threshold");

    property p_gap;
        (state_q == bmba_pkg::BMBA_LOCAL && loc_end && !abort && rem_ok) |=>
            (state_q == bmba_pkg::BMBA_GAP) && grant_q == '0;
    endproperty
    a_gap: assert property (p_gap) else $error("no gap after local");

    property p_remote_word;
        ($rose(grant_q.remote_dma) && !abort && !$rose(err_any)) |->
            s_remote_word ##1 s_release;
    endproperty
    a_remote_word: assert property (p_remote_word) else $error("remote word length");

    property p_shared_no_remote;
        grant_q.remote_dma |-> !$past(shared_q);
    endproperty
    a_shared_no_remote: assert property (p_shared_no_remote) else $error("remote in shared");

endmodule
`default_nettype wire

/* src/bmba_pkg.sv */
// Purpose: Types shared by the memory bus arbiter.
// Assumes: The register header is on the include path.
// Notes:   State codes are one-hot so a status read shows the state directly.
`include "bmba_regs.svh"

package bmba_pkg;

    typedef enum logic [5:0] {
        BMBA_RESET  = `BMBA_ST_RESET,
        BMBA_IDLE   = `BMBA_ST_IDLE,
        BMBA_LOCAL  = `BMBA_ST_LOCAL,
        BMBA_REMOTE = `BMBA_ST_REMOTE,
        BMBA_GAP    = `BMBA_ST_GAP,
        BMBA_CPU    = `BMBA_ST_CPU
    } bmba_state_t;

    typedef struct packed {
        logic local_dma;
        logic remote_dma;
        logic cpu;
    } bmba_grant_t;

    typedef struct packed {
        logic [3:0] thresh;
        logic [3:0] burst;
    } bmba_cfg_t;

endpackage

/* src/bmba_regs.svh */
// Purpose: Named offsets, fields, reset values and counts of the memory bus arbiter.
// Assumes: Included by its bare name from the package and the arbiter.
// Notes:   Every register is one aligned 32-bit word; unused bits read as zero.
`ifndef BMBA_REGS_SVH
`define BMBA_REGS_SVH

`define BMBA_OFF_CTRL       8'h00
`define BMBA_OFF_CFG        8'h04
`define BMBA_OFF_STAT       8'h08
`define BMBA_OFF_ISR        8'h0c
`define BMBA_OFF_IMR        8'h10

`define BMBA_CTRL_START     0
`define BMBA_CTRL_STOP      1
`define BMBA_CTRL_RRESET    2
`define BMBA_CTRL_SHARED    3

`define BMBA_CFG_BURST_LO   0
`define BMBA_CFG_BURST_HI   3
`define BMBA_CFG_THR_LO     4
`define BMBA_CFG_THR_HI     7
`define BMBA_CFG_BURST_RST  4'h8
`define BMBA_CFG_THR_RST    4'h8

`define BMBA_INT_ERR        0
`define BMBA_INT_BURST      1
`define BMBA_INT_WORD       2
`define BMBA_INT_W          3

`define BMBA_ST_RESET       6'h01
`define BMBA_ST_IDLE        6'h02
`define BMBA_ST_LOCAL       6'h04
`define BMBA_ST_REMOTE      6'h08
`define BMBA_ST_GAP         6'h10
`define BMBA_ST_CPU         6'h20

`define BMBA_WORD_LAST      2'h1
`define BMBA_BURST_FULL     5'h10
`define BMBA_RESP_OKAY      2'h0
`define BMBA_RESP_SLVERR    2'h2

`endif

/* tb/bmba_far_model.sv */
// Purpose: Remote DMA requester that sits behind the arbiter's remote port.
// Assumes: One remote word holds the grant for two cycles.
// Notes:   The request stays up while programmed words remain.
`timescale 1ns/1ns
`default_nettype none

module bmba_far_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       remote_gnt,
    input  wire logic       load,
    input  wire logic [7:0] words,
    output logic            rdma_req
);
    logic [7:0] left_q;
    logic       half_q;

    // The count drops on the second grant cycle, so the arbiter never sees a stale request.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            left_q <= 8'h00;
            half_q <= 1'b0;
        end else if (load) begin
            left_q <= left_q + words;
        end else if (remote_gnt) begin
            half_q <= !half_q;
            if (half_q) begin
                left_q <= left_q - 8'h01;
            end
        end
    end

    assign rdma_req = (left_q != 8'h00);
endmodule
`default_nettype wire

/* tb/test_buffer_memory_bus_arbiter.sv */
// Purpose: Self-checking bench of the memory bus arbiter.
// Assumes: Register map and timing as the package header declares.
// Notes:   Stimulus is random with seed 71, plus hand-picked corner cases.
`timescale 1ns/1ns
`default_nettype none
`include "bmba_regs.svh"

module test_buffer_memory_bus_arbiter;
    logic                  aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic                  s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic                  s_axi_arready, s_axi_rvalid, s_axi_rready, fifo_req, rdma_req;
    logic                  cpu_req, mem_cycle_q, rxtx_en_q, burst_done_q, word_done_q;
    logic                  irq_q, load, prev_l, prev_r;
    logic [7:0]            s_axi_awaddr, s_axi_araddr, nwords;
    logic [31:0]           s_axi_wdata, s_axi_rdata, rd_d;
    logic [3:0]            s_axi_wstrb;
    logic [1:0]            s_axi_bresp, s_axi_rresp, rd_r;
    logic [4:0]            fifo_level;
    logic [2:0]            err;
    bmba_pkg::bmba_grant_t grant_q;
    int                    fail_count, samples_checked, viol, direct, nb, nw, lrun, rrun;
    int                    last_l, cycles, w0, b0;

    bmba_arbiter dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fifo_req, .fifo_level, .rdma_req,
        .cpu_req, .fifo_underrun(err[0]), .fifo_overrun(err[1]), .ring_overflow(err[2]),
        .grant_q, .mem_cycle_q, .rxtx_en_q, .burst_done_q, .word_done_q, .irq_q);

    bmba_far_model far_u (.aclk, .aresetn, .remote_gnt(grant_q.remote_dma), .load,
        .words(nwords), .rdma_req);

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus watch: one grant, matching memory cycles, two-cycle words, a gap after local.
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            summarize();
        end
        if (!aresetn) begin
            lrun = 0;
            rrun = 0;
            prev_l = 1'b0;
            prev_r = 1'b0;
        end else begin
            if ($countones(grant_q) > 1) viol++;
            if (mem_cycle_q !== (grant_q.local_dma | grant_q.remote_dma)) viol++;
            if (grant_q.local_dma === 1'b1) lrun++;
            else if (lrun != 0) begin
                last_l = lrun;
                lrun = 0;
            end
            if (grant_q.remote_dma === 1'b1) rrun++;
            else if (rrun != 0) begin
                if (rrun != 2) viol++;
                rrun = 0;
            end
            if (prev_l && grant_q.remote_dma) viol++;
            if (prev_r && grant_q.local_dma) direct++;
            prev_l = grant_q.local_dma;
            prev_r = grant_q.remote_dma;
            if (burst_done_q === 1'b1) nb++;
            if (word_done_q === 1'b1) nw++;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (fail_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit done = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                rd_r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a);
        bit done = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                rd_d = s_axi_rdata;
                rd_r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1;
            end
        end
    endtask

    task automatic wait_cnt(ref int c, input int target);
        int k = 0;
        while (c < target && k < 300) begin
            @(posedge aclk);
            k++;
        end
    endtask

    task automatic wait_local();
        int k = 0;
        while (grant_q.local_dma !== 1'b1 && k < 300) begin
            @(posedge aclk);
            k++;
        end
        fifo_req <= 1'b0;
    endtask

    task automatic give_words(input logic [7:0] n);
        @(posedge aclk);
        load <= 1'b1;
        nwords <= n;
        @(posedge aclk);
        load <= 1'b0;
    endtask

    // A level equal to the threshold must not start a burst; one above it must.
    task automatic do_burst(input logic [3:0] b, input logic [3:0] t);
        wr(`BMBA_OFF_CFG, {24'h0, t, b});
        b0 = nb;
        fifo_level <= {1'b0, t};
        fifo_req <= 1'b1;
        cyc(6);
        check(32'(grant_q.local_dma), 32'h0);
        fifo_level <= {1'b0, t} + 5'h01;
        wait_local();
        check(32'(mem_cycle_q), 32'h1);
        wait_cnt(nb, b0 + 1);
        check(last_l, (b == 4'h0) ? 32'h10 : 32'(b));
        check(nb - b0, 32'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {fifo_req, cpu_req, load, err, fifo_level, nwords} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        aresetn = 1'b0;
        void'($urandom(71));
        cyc(20);
        aresetn <= 1'b1;
        cyc(1);
        check(32'(grant_q), 32'h0);
        s_axi_wstrb <= 4'he;
        wr(`BMBA_OFF_CTRL, 32'h1);
        s_axi_wstrb <= 4'hf;
        rd(`BMBA_OFF_STAT);
        check(rd_d, 32'h01);
        wr(`BMBA_OFF_CTRL, 32'h1);
        rd(`BMBA_OFF_STAT);
        check(rd_d, 32'h42);
        for (int i = 0; i < 6; i++) begin
            do_burst((i == 0) ? 4'h0 : (i == 1) ? 4'h1 : (i == 2) ? 4'hf : 4'($urandom),
                4'($urandom));
        end
        w0 = nw;
        give_words(8'h03);
        wait_cnt(nw, w0 + 3);
        check(nw - w0, 32'h3);
        // Local request raised in mid-word must take the bus right after that word.
        wr(`BMBA_OFF_CFG, 32'h24);
        w0 = nw;
        b0 = nb;
        give_words(8'h06);
        while (grant_q.remote_dma !== 1'b1) @(posedge aclk);
        fifo_level <= 5'h03;
        fifo_req <= 1'b1;
        wait_local();
        wait_cnt(nw, w0 + 6);
        check(nw - w0, 32'h6);
        check(nb - b0, 32'h1);
        check(32'(direct != 0), 32'h1);
        wr(`BMBA_OFF_CTRL, 32'h8);
        w0 = nw;
        cpu_req <= 1'b1;
        give_words(8'h02);
        cyc(4);
        check(32'(grant_q.cpu), 32'h1);
        check(32'(grant_q.remote_dma), 32'h0);
        cpu_req <= 1'b0;
        cyc(3);
        check(nw - w0, 32'h0);
        wr(`BMBA_OFF_CTRL, 32'h0);
        wait_cnt(nw, w0 + 2);
        check(nw - w0, 32'h2);
        wr(`BMBA_OFF_IMR, 32'h2);
        cyc(2);
        check(32'(irq_q), 32'h1);
        wr(`BMBA_OFF_ISR, 32'h7);
        cyc(2);
        check(32'(irq_q), 32'h0);
        wr(`BMBA_OFF_IMR, 32'h1);
        for (int i = 0; i < 5; i++) begin
            wr(`BMBA_OFF_CTRL, 32'h1);
            rd(`BMBA_OFF_STAT);
            check(rd_d, 32'h42);
            if (i < 3) begin
                err <= 3'(1 << i);
                @(posedge aclk);
                err <= 3'h0;
            end else begin
                wr(`BMBA_OFF_CTRL, (i == 3) ? 32'h2 : 32'h4);
            end
            cyc(2);
            rd(`BMBA_OFF_STAT);
            check(rd_d, 32'h01);
            check(32'(rxtx_en_q), 32'h0);
        end
        check(32'(irq_q), 32'h1);
        rd(8'h20);
        check(32'(rd_r), 32'h2);
        check(rd_d, 32'h0);
        wr(8'h20, 32'h1);
        check(32'(rd_r), 32'h2);
        wr(`BMBA_OFF_CTRL, 32'h1);
        aresetn <= 1'b0;
        cyc(2);
        aresetn <= 1'b1;
        rd(`BMBA_OFF_STAT);
        check(rd_d, 32'h01);
        check(viol, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
